/* File: hw/ecp_pkg.sv */
// Purpose: shared constants for the enhanced capture/compare/pwm unit
// Assumes: apb register map with one aligned 32-bit word per register
// Notes: all offsets are byte addresses
package ecp_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DUTY = 8'h04;
  localparam logic [7:0] OFS_CMP = 8'h08;
  localparam logic [7:0] OFS_CAPT = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_DEAD = 8'h18;
  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] CFG_RST = 6'h03;
  // ==========================================================
  // field positions
  localparam int unsigned CTRL_STEER_LSB = 6;
  localparam int unsigned CTRL_DUTY_LSB = 4;
  localparam int unsigned CFG_PIN_SEL = 0;
  localparam int unsigned CFG_RELOCATE = 1;
  localparam int unsigned CFG_WIDTH_LSB = 2;
  localparam int unsigned CFG_EXT_MODE = 4;
  localparam int unsigned CFG_BUS_ACTIVE = 5;
  localparam int unsigned STAT_MATCH = 0;
  localparam int unsigned STAT_CMP_OUT = 1;
  localparam int unsigned STAT_PIN = 2;
  // ==========================================================
  // mode selector codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAPT_ANY = 4'h3;
  localparam logic [3:0] MODE_CAPT_FALL = 4'h4;
  localparam logic [3:0] MODE_CAPT_RISE = 4'h5;
  localparam logic [3:0] MODE_CAPT_4 = 4'h6;
  localparam logic [3:0] MODE_CAPT_16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_EVENT = 4'hb;
  // ==========================================================
  // output steering and bus width codes
  localparam logic [1:0] STEER_SINGLE = 2'h0;
  localparam logic [1:0] STEER_FWD = 2'h1;
  localparam logic [1:0] STEER_HALF = 2'h2;
  localparam logic [1:0] STEER_REV = 2'h3;
  localparam logic [1:0] BUS_WIDTH_12 = 2'h1;
  localparam logic [1:0] PIN_C1 = 2'h0;
  localparam logic [1:0] PIN_E7 = 2'h1;
  localparam logic [1:0] PIN_B3 = 2'h2;
  // ==========================================================
  // capture prescaler terminal counts
  localparam logic [3:0] CAPT_DIV4_END = 4'h3;
  localparam logic [3:0] CAPT_DIV16_END = 4'hf;
  // ==========================================================
  // dead-band sequencer
  typedef enum logic [1:0] {
    DB_RUN = 2'b00,
    DB_GAP = 2'b01
  } ecp_db_type;
endpackage

/* File: hw/ecp_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to CLOCK
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module ecp_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } ecp_sync_type;
  ecp_sync_type q;
  ecp_sync_type d;
  // ==========================================================
  // first stage feeds only the second
  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.out = q.s3;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign sync_out = q.out;
endmodule

/* File: hw/ecp_unit.sv */
// Purpose: control and output steering of one enhanced capture/compare/pwm unit
// Assumes: apb slave, 25 MHz CLOCK, timers live outside this block
// Notes: UNIT_INDEX picks unit one, two or three behaviour
// ==========================================================
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module ecp_unit #(
  parameter int unsigned UNIT_INDEX = 1
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CAPTURE_PIN,
  input wire logic [15:0] TIMER_VALUE,
  input wire logic [9:0] PWM_COUNT,
  input wire logic PWM_PERIOD_END,
  input wire logic ADC_ENABLED,
  output logic OUT_A,
  output logic OUT_A_OE,
  output logic OUT_B,
  output logic OUT_B_OE,
  output logic OUT_C,
  output logic OUT_C_OE,
  output logic OUT_D,
  output logic OUT_D_OE,
  output logic TIMER_RESET,
  output logic ADC_START,
  output logic MATCH_FLAG,
  output logic B_C_ON_PORT_H,
  output logic B_C_BLOCKED,
  output logic [1:0] A_PIN_SEL,
  output logic STD_UNIT_OVERRIDE
);
  import ecp_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] duty_hi;
    logic [15:0] cmp;
    logic [15:0] capt;
    logic [5:0] cfg;
    logic [6:0] dead;
    logic match;
    logic [3:0] mode_prev;
    logic hit_prev;
    logic pin_prev;
    logic cmp_out;
    logic [3:0] presc;
    logic [9:0] pwm_duty;
    logic pwm_raw;
    ecp_db_type db_state;
    logic [6:0] db_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] out;
    logic [3:0] oe;
    logic timer_reset;
    logic adc_start;
    logic bc_h;
    logic bc_blk;
    logic [1:0] a_sel;
    logic std_ovr;
  } ecp_state_type;

  ecp_state_type q;
  ecp_state_type d;
  logic pin_s;

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m[3:2] == 2'b11);
  endfunction

  // ==========================================================
  // capture input synchroniser
  ecp_sync u_sync (
    .clk(CLOCK),
    .srst(SRST),
    .async_in(CAPTURE_PIN),
    .sync_out(pin_s)
  );

  logic [3:0] mode;
  logic [1:0] steer;
  logic entered;
  logic hit_new;
  logic rise;
  logic fall;
  logic bus_start;
  logic wr;
  logic unit13;
  logic clr_req;
  assign mode = q.ctrl[3:0];
  assign steer = q.ctrl[CTRL_STEER_LSB +: 2];
  assign entered = (mode != q.mode_prev);
  assign hit_new = (TIMER_VALUE == q.cmp) && !q.hit_prev;
  assign rise = pin_s && !q.pin_prev;
  assign fall = !pin_s && q.pin_prev;
  assign bus_start = PSEL && PENABLE && !q.pready;
  assign wr = PSEL && PENABLE && PWRITE && q.pready;
  assign unit13 = (UNIT_INDEX != 2);
  assign clr_req = wr && (PADDR == OFS_STAT) && PWDATA[STAT_MATCH];

  // ==========================================================
  // next-state logic
  always_comb begin
    logic capt_ev;
    logic match_set;
    logic match_clr;
    logic pol_ac;
    logic pol_bd;
    logic run;
    logic [31:0] rd;
    logic hit_map;
    capt_ev = 1'b0;
    match_set = 1'b0;
    match_clr = 1'b0;
    pol_ac = mode[1];
    pol_bd = mode[0];
    run = 1'b0;
    rd = '0;
    hit_map = 1'b1;
    d = q;
    d.mode_prev = mode;
    d.hit_prev = (TIMER_VALUE == q.cmp);
    d.pin_prev = pin_s;
    d.timer_reset = 1'b0;
    d.adc_start = 1'b0;

    // apb read mux, unmapped gives slave error
    case (PADDR)
      OFS_CTRL: rd = {24'h000000, q.ctrl};
      OFS_DUTY: rd = {24'h000000, q.duty_hi};
      OFS_CMP: rd = {16'h0000, q.cmp};
      OFS_CAPT: rd = {16'h0000, q.capt};
      OFS_CFG: rd = {26'h0000000, q.cfg};
      OFS_STAT: rd = {29'h00000000, pin_s, q.cmp_out, q.match};
      OFS_DEAD: rd = {25'h0000000, q.dead};
      default: hit_map = 1'b0;
    endcase
    d.pready = bus_start;
    if (bus_start) begin
      d.prdata = PWRITE ? 32'h00000000 : rd;
      d.pslverr = !hit_map;
    end
    if (wr && hit_map) begin
      case (PADDR)
        OFS_CTRL: d.ctrl = PWDATA[7:0];
        OFS_DUTY: d.duty_hi = PWDATA[7:0];
        OFS_CMP: d.cmp = PWDATA[15:0];
        OFS_CFG: d.cfg = PWDATA[5:0];
        OFS_STAT: match_clr = PWDATA[STAT_MATCH];
        OFS_DEAD: d.dead = PWDATA[6:0];
        default: d.dead = q.dead;
      endcase
    end

    // capture and compare engines
    if (mode == MODE_OFF || entered) begin
      d.presc = '0;
    end
    case (mode)
      MODE_CAPT_ANY: capt_ev = rise || fall;
      MODE_CAPT_FALL: capt_ev = fall;
      MODE_CAPT_RISE: capt_ev = rise;
      MODE_CAPT_4, MODE_CAPT_16: begin
        if (rise && !entered) begin
          if (q.presc == (mode[0] ? CAPT_DIV16_END : CAPT_DIV4_END)) begin
            capt_ev = 1'b1;
            d.presc = '0;
          end else begin
            d.presc = q.presc + 4'h1;
          end
        end
      end
      MODE_TOGGLE: begin
        if (hit_new) begin
          d.cmp_out = !q.cmp_out;
          match_set = 1'b1;
        end
      end
      MODE_CMP_SET, MODE_CMP_CLR: begin
        if (entered) begin
          d.cmp_out = mode[0];
        end else if (hit_new) begin
          d.cmp_out = !mode[0];
          match_set = 1'b1;
        end
      end
      MODE_CMP_SOFT: match_set = hit_new;
      MODE_CMP_EVENT: begin
        match_set = hit_new;
        if (UNIT_INDEX != 3) begin
          // unit three has no special event, so it stops at the flag
          d.timer_reset = hit_new;
          d.adc_start = hit_new && (UNIT_INDEX == 2) && ADC_ENABLED;
        end
      end
      default: capt_ev = 1'b0;
    endcase
    if (mode == MODE_OFF) begin
      d.cmp_out = 1'b0;
      d.pwm_duty = '0;
      d.db_state = DB_RUN;
      d.db_cnt = '0;
    end
    if (capt_ev) begin
      d.capt = TIMER_VALUE;
      match_set = 1'b1;
    end
    // a set in the same cycle as a clear wins
    d.match = (q.match && !match_clr) || match_set;

    // pwm duty double buffer, latched at the period end
    if (is_pwm(mode) && PWM_PERIOD_END) begin
      d.pwm_duty = {q.duty_hi, q.ctrl[CTRL_DUTY_LSB +: 2]};
    end
    d.pwm_raw = is_pwm(mode) && (PWM_COUNT < q.pwm_duty);

    // dead band: both half-bridge outputs idle for dead cycles per edge
    case (q.db_state)
      DB_RUN: begin
        if (d.pwm_raw != q.pwm_raw && q.dead != 7'h00) begin
          d.db_state = DB_GAP;
          d.db_cnt = q.dead;
        end
      end
      DB_GAP: begin
        d.db_cnt = q.db_cnt - 7'h01;
        if (q.db_cnt <= 7'h01) begin
          d.db_state = DB_RUN;
        end
      end
      default: d.db_state = DB_RUN;
    endcase
    run = (d.db_state == DB_RUN);

    // pin mapping
    d.bc_blk = unit13 && q.cfg[CFG_EXT_MODE] && q.cfg[CFG_BUS_ACTIVE]
      && q.cfg[CFG_RELOCATE]
      && (q.cfg[CFG_WIDTH_LSB +: 2] != BUS_WIDTH_12);
    d.bc_h = unit13 && !q.cfg[CFG_RELOCATE];
    if (UNIT_INDEX != 2 || q.cfg[CFG_PIN_SEL]) begin
      d.a_sel = PIN_C1;
    end else begin
      d.a_sel = q.cfg[CFG_EXT_MODE] ? PIN_B3 : PIN_E7;
    end
    d.std_ovr = unit13 && is_pwm(mode) && steer[0] && !d.bc_blk;

    // output steering, index 0..3 is A..D
    d.out = '0;
    d.oe = '0;
    if (is_pwm(mode)) begin
      case (steer)
        STEER_SINGLE: begin
          d.out[0] = d.pwm_raw ^ pol_ac;
          d.oe = 4'h1;
        end
        STEER_FWD: begin
          d.out = {d.pwm_raw ^ pol_bd, pol_ac, pol_bd, !pol_ac};
          d.oe = 4'hf;
        end
        STEER_HALF: begin
          d.out[0] = (d.pwm_raw && run) ^ pol_ac;
          d.out[1] = (!d.pwm_raw && run) ^ pol_bd;
          d.oe = 4'h3;
        end
        default: begin
          d.out = {pol_bd, !pol_ac, d.pwm_raw ^ pol_bd, pol_ac};
          d.oe = 4'hf;
        end
      endcase
      if (d.bc_blk) begin
        // the external bus owns these pins; only single output survives
        d.oe = d.oe & 4'h9;
        if (steer[0]) begin
          d.oe = 4'h1;
        end
      end
    end else begin
      d.out[0] = d.cmp_out;
      case (mode)
        MODE_TOGGLE, MODE_CMP_SET, MODE_CMP_CLR: d.oe = 4'h1;
        default: d.oe = 4'h0;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.cfg <= CFG_RST;
    end else begin
      q <= d;
    end
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign OUT_A = q.out[0];
  assign OUT_B = q.out[1];
  assign OUT_C = q.out[2];
  assign OUT_D = q.out[3];
  assign OUT_A_OE = q.oe[0];
  assign OUT_B_OE = q.oe[1];
  assign OUT_C_OE = q.oe[2];
  assign OUT_D_OE = q.oe[3];
  assign TIMER_RESET = q.timer_reset;
  assign ADC_START = q.adc_start;
  assign MATCH_FLAG = q.match;
  assign B_C_ON_PORT_H = q.bc_h;
  assign B_C_BLOCKED = q.bc_blk;
  assign A_PIN_SEL = q.a_sel;
  assign STD_UNIT_OVERRIDE = q.std_ovr;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);

  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence

  property p_off;
    (mode == MODE_OFF) |=> !OUT_A_OE && !OUT_B_OE && !OUT_C_OE && !OUT_D_OE && !q.cmp_out;
  endproperty
  a_off: assert property (p_off) else $error("unit off but outputs driven");

  property p_toggle;
    (mode == MODE_TOGGLE) && !entered && hit_new |=> OUT_A == !$past(q.cmp_out) && MATCH_FLAG;
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match missing");

  property p_capt;
    (mode == MODE_CAPT_RISE) && rise |=> q.capt == $past(TIMER_VALUE) && MATCH_FLAG;
  endproperty
  a_capt: assert property (p_capt) else $error("rising capture missed");

  property p_set_entry;
    (mode == MODE_CMP_SET) && entered |=> !OUT_A && OUT_A_OE;
  endproperty
  a_set_entry: assert property (p_set_entry) else $error("pin not low on entry");

  property p_clr_entry;
    (mode == MODE_CMP_CLR) && entered |=> OUT_A && OUT_A_OE;
  endproperty
  a_clr_entry: assert property (p_clr_entry) else $error("pin not high on entry");

  property p_soft;
    (mode == MODE_CMP_SOFT) |=> !OUT_A_OE && !TIMER_RESET;
  endproperty
  a_soft: assert property (p_soft) else $error("soft mode drives pin");

  property p_event;
    (UNIT_INDEX != 3) && (mode == MODE_CMP_EVENT) && hit_new |=> s_pulse(TIMER_RESET);
  endproperty
  a_event: assert property (p_event) else $error("special event reset wrong");

  property p_no_event3;
    (UNIT_INDEX == 3) |-> !TIMER_RESET && !ADC_START;
  endproperty
  a_no_event3: assert property (p_no_event3) else $error("unit three raised event");

  property p_fwd;
    is_pwm(mode) && (steer == STEER_FWD) && !q.bc_blk ##1 $stable(q.ctrl)
      |-> OUT_A == !mode[1] && OUT_B == mode[0] && OUT_C == mode[1];
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward bridge levels wrong");

  property p_set_wins;
    q.match |=> MATCH_FLAG || $past(clr_req);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("match flag lost");

  property p_ready;
    PREADY |=> !PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("pready longer than one cycle");
endmodule

/* File: tb/ecp_bridge_model.sv */
// Purpose: behavioural bridge driver stage fed by the four steered outputs
// Assumes: driver inputs carry pull-downs
// Notes: a pin not driven reads low, never the last driven level
`timescale 1ns/1ps
module ecp_bridge_model (
  input wire logic [3:0] out,
  input wire logic [3:0] oe,
  input wire logic [3:0] dir_out,
  output logic [3:0] pin
);
  // ==========================================================
  // pin resolution
  // a port left as input never reaches the driver, wherever the unit is mapped
  assign pin = out & oe & dir_out;
endmodule

/* File: tb/test_enhanced_capture_compare_pwm_control.sv */
// Purpose: self-checking bench for one enhanced capture/compare/pwm unit
// Assumes: unit one, timebases driven directly by the bench
// Notes: pins are judged through the bridge model, so released pins read low
`timescale 1ns/1ps
module test_enhanced_capture_compare_pwm_control;
  import ecp_pkg::*;
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic CAPTURE_PIN = 1'b0;
  logic [15:0] TIMER_VALUE = 16'h0;
  logic [9:0] PWM_COUNT = 10'h0;
  logic PWM_PERIOD_END = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, timer_reset, adc_start, match_flag, saw_tr, saw_adc;
  logic b_c_on_port_h, b_c_blocked, std_unit_override;
  logic [1:0] a_pin_sel;
  logic [3:0] out_vec, oe_vec, pins;
  logic save;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  ecp_unit #(.UNIT_INDEX(1)) ecp_unit_inst (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CAPTURE_PIN(CAPTURE_PIN), .TIMER_VALUE(TIMER_VALUE),
    .PWM_COUNT(PWM_COUNT), .PWM_PERIOD_END(PWM_PERIOD_END), .ADC_ENABLED(1'b1),
    .OUT_A(out_vec[0]), .OUT_A_OE(oe_vec[0]), .OUT_B(out_vec[1]), .OUT_B_OE(oe_vec[1]),
    .OUT_C(out_vec[2]), .OUT_C_OE(oe_vec[2]), .OUT_D(out_vec[3]), .OUT_D_OE(oe_vec[3]),
    .TIMER_RESET(timer_reset), .ADC_START(adc_start), .MATCH_FLAG(match_flag),
    .B_C_ON_PORT_H(b_c_on_port_h), .B_C_BLOCKED(b_c_blocked), .A_PIN_SEL(a_pin_sel),
    .STD_UNIT_OVERRIDE(std_unit_override));
  ecp_bridge_model ecp_bridge_model_inst (.out(out_vec), .oe(oe_vec), .dir_out(4'hf),
    .pin(pins));

  // ==========================================================
  // clock, watchdog and reporting
  always #20 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ==========================================================
  // bus and stimulus tasks
  task tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask

  // request held until pready is seen high; one idle cycle keeps drives apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (pready !== 1'b1) @(posedge CLOCK);
    rd = prdata;
    err = pslverr;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task edge_cap(input logic [15:0] v, input logic lvl);
    TIMER_VALUE <= v;
    CAPTURE_PIN <= lvl;
    tick(8);
  endtask

  task match();
    saw_tr = 1'b0;
    saw_adc = 1'b0;
    TIMER_VALUE <= 16'h0055;
    @(posedge CLOCK);
    TIMER_VALUE <= 16'h0000;
    repeat (4) begin
      @(posedge CLOCK);
      saw_tr = saw_tr | timer_reset;
      saw_adc = saw_adc | adc_start;
    end
  endtask

  task cmp_case(input logic [7:0] ctl, input logic [4:0] entry, input logic [4:0] after,
                input logic tr);
    apb(1'b1, OFS_STAT, 32'h1);
    apb(1'b1, OFS_CTRL, {24'h0, ctl});
    tick(3);
    chk("flag cleared", match_flag, 1'b0);
    chk("pins on entry", {oe_vec, out_vec[0] & oe_vec[0]}, entry);
    match();
    chk("pins after match", {oe_vec, out_vec[0] & oe_vec[0]}, after);
    chk("match flag", match_flag, 1'b1);
    chk("timer reset", saw_tr, tr);
  endtask

  task prescale(input logic [3:0] mode, input int n, input logic [15:0] prev);
    apb(1'b1, OFS_CTRL, {28'h0, mode});
    for (int k = 1; k <= n; k++) begin
      if (k == n) rdchk("capture early", OFS_CAPT, prev);
      edge_cap(k[15:0], 1'b1);
      edge_cap(16'h0, 1'b0);
    end
    rdchk("capture prescaled", OFS_CAPT, n[15:0]);
  endtask

  task period();
    PWM_PERIOD_END <= 1'b1;
    @(posedge CLOCK);
    PWM_PERIOD_END <= 1'b0;
    tick(10);
  endtask

  // oe in the upper nibble, driver pin levels below; bit 0 is output a
  function automatic logic [7:0] steer_exp(input logic [1:0] s, input logic [1:0] p,
                                           input logic r);
    logic [3:0] oe;
    logic [3:0] act;
    oe = (s == 2'h0) ? 4'h1 : (s == 2'h2) ? 4'h3 : 4'hf;
    act = (s == 2'h0) ? {3'h0, r} : (s == 2'h1) ? {r, 3'h1} :
          (s == 2'h2) ? {2'h0, ~r, r} : {2'h1, r, 1'b0};
    return {oe, (act ^ {p[0], p[1], p[0], p[1]}) & oe};
  endfunction

  // ==========================================================
  // test sequence
  initial begin
    tick(16);
    SRST <= 1'b0;
    tick(2);
    rdchk("control reset", OFS_CTRL, 32'h0);
    rdchk("config reset", OFS_CFG, 32'h3);
    chk("pin select", a_pin_sel, PIN_C1);
    chk("port e default", b_c_on_port_h, 1'b0);
    apb(1'b1, OFS_CTRL, 32'hffff_ffa5);
    rdchk("control readback", OFS_CTRL, 32'ha5);
    chk("mapped no error", err, 1'b0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("test registers done");
    apb(1'b1, OFS_CTRL, 32'h5);
    edge_cap(16'h1111, 1'b1);
    rdchk("capture rise", OFS_CAPT, 32'h1111);
    edge_cap(16'h2222, 1'b0);
    rdchk("capture no fall", OFS_CAPT, 32'h1111);
    apb(1'b1, OFS_CTRL, 32'h4);
    edge_cap(16'h3333, 1'b1);
    edge_cap(16'h4444, 1'b0);
    rdchk("capture fall", OFS_CAPT, 32'h4444);
    prescale(4'h6, 4, 16'h4444);
    prescale(4'h7, 16, 16'h0004);
    apb(1'b1, OFS_CTRL, 32'h3);
    edge_cap(16'h5555, 1'b1);
    rdchk("capture any rise", OFS_CAPT, 32'h5555);
    edge_cap(16'h6666, 1'b0);
    rdchk("capture any fall", OFS_CAPT, 32'h6666);
    $display("test capture done");
    apb(1'b1, OFS_CMP, 32'h55);
    cmp_case(8'hc8, 5'b00010, 5'b00011, 1'b0);
    cmp_case(8'h49, 5'b00011, 5'b00010, 1'b0);
    cmp_case(8'h8a, 5'b00000, 5'b00000, 1'b0);
    apb(1'b1, OFS_STAT, 32'h1);
    apb(1'b1, OFS_CTRL, 32'hb);
    match();
    chk("event reset", saw_tr, 1'b1);
    chk("event flag", match_flag, 1'b1);
    chk("no conversion unit one", saw_adc, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h2);
    tick(3);
    save = out_vec[0];
    match();
    chk("toggle one", out_vec[0], !save);
    match();
    chk("toggle two", out_vec[0], save);
    $display("test compare done");
    apb(1'b1, OFS_DUTY, 32'h0);
    apb(1'b1, OFS_DEAD, 32'h2);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        for (int r = 0; r < 2; r++) begin
          apb(1'b1, OFS_CTRL, {24'h0, s[1:0], 1'b0, r[0], 2'h3, p[1:0]});
          period();
          chk("steering", {oe_vec, pins}, steer_exp(s[1:0], p[1:0], r[0]));
          chk("std override", std_unit_override, s[0]);
        end
      end
    end
    apb(1'b1, OFS_CTRL, 32'hc);
    apb(1'b1, OFS_DUTY, 32'h1);
    PWM_COUNT <= 10'h3;
    period();
    chk("duty high byte on", pins[0], 1'b1);
    PWM_COUNT <= 10'h4;
    tick(4);
    chk("duty high byte off", pins[0], 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1c);
    PWM_COUNT <= 10'h3;
    tick(4);
    chk("latch cleared by off", pins[0], 1'b0);
    PWM_COUNT <= 10'h4;
    period();
    chk("duty low bits", pins[0], 1'b1);
    PWM_COUNT <= 10'h0;
    $display("test pwm done");
    apb(1'b1, OFS_CFG, 32'h33);
    apb(1'b1, OFS_CTRL, 32'hcc);
    tick(3);
    chk("bus blocks", b_c_blocked, 1'b1);
    chk("blocked drive", oe_vec, 4'h1);
    apb(1'b1, OFS_CFG, 32'h37);
    tick(3);
    chk("narrow bus", b_c_blocked, 1'b0);
    chk("narrow drive", oe_vec, 4'hf);
    apb(1'b1, OFS_CFG, 32'h31);
    tick(3);
    chk("port h", b_c_on_port_h, 1'b1);
    chk("port h free", b_c_blocked, 1'b0);
    $display("test pin mapping done");
    summarize();
  end
endmodule
